// [core/qpc_channel.sv]
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
module qpc_channel (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [15:0] RDATA,
    // channel pins
    input  wire logic        IN_A,
    input  wire logic        IN_B,
    input  wire logic        IN_C,
    input  wire logic        CARRIER_32M,
    output logic             CNT_OUT,
    output logic             INT_REQ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]         cfg_q;
    logic [15:0]         const_a_q;
    logic [15:0]         const_b_q;
    logic [16:0]         cnt_q;
    logic [16:0]         cnt_d;
    logic [2:0]          flt_p_q;
    logic [23:0]         acc_q;
    logic                tick_q;
    logic                run_q;
    logic                pend_q;
    logic                out_q;
    logic [15:0]         rdata_q;
    qpc_pkg::qpc_state_t state_q;
    qpc_pkg::qpc_state_t state_d;
    logic [2:0]          flt;

    // ------------------------------------------------------------
    // input filters
    // ------------------------------------------------------------
    wire [2:0] raw_in = {IN_C, IN_B, IN_A};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flt
            qpc_deglitch u_flt (
                .clk   (REF_CLK),
                .rst   (RESET),
                .en    (cfg_q[qpc_pkg::DEB_BIT]),
                .raw   (raw_in[gi]),
                .clean (flt[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire       wr_cfg   = WR_STB && ADDR == qpc_pkg::OFF_CFG;
    wire       wr_trig  = WR_STB && ADDR == qpc_pkg::OFF_TRIG;
    wire       wr_ca    = WR_STB && ADDR == qpc_pkg::OFF_CONST_A;
    wire       wr_cb    = WR_STB && ADDR == qpc_pkg::OFF_CONST_B;
    wire       irq_clr  = WR_STB && ADDR == qpc_pkg::OFF_IRQ_STAT && WDATA[0];
    wire [2:0] mode     = cfg_q[2:0];
    wire       is_quad  = mode == qpc_pkg::MODE_QUAD;
    wire       is_pwm   = mode == qpc_pkg::MODE_PWM;
    wire       pol      = cfg_q[qpc_pkg::POL_BIT];
    wire       ien      = cfg_q[qpc_pkg::IEN_BIT];
    wire [1:0] sel54    = cfg_q[5:4];
    wire [1:0] sel76    = cfg_q[7:6];
    wire [1:0] sel98    = cfg_q[9:8];
    wire [2:0] iph      = cfg_q[9:7];
    wire [1:0] icond    = cfg_q[11:10];
    wire [2:0] clk_src  = cfg_q[12:10];
    wire       wr_quad  = WDATA[2:0] == qpc_pkg::MODE_QUAD;
    // spare bits never stored so a later mode switch cannot expose them
    wire [15:0] cfg_wr  = {WDATA[15], 1'b0, WDATA[13], WDATA[12] & ~wr_quad, WDATA[11:0]};

    // ------------------------------------------------------------
    // quadrature decode
    // ------------------------------------------------------------
    wire a      = flt[0];
    wire b_eff  = flt[1] & cfg_q[qpc_pkg::CHB_BIT];
    wire b_pe   = flt_p_q[1] & cfg_q[qpc_pkg::CHB_BIT];
    wire a_rise = a & ~flt_p_q[0];
    wire a_fall = ~a & flt_p_q[0];
    wire b_rise = b_eff & ~b_pe;
    wire b_fall = ~b_eff & b_pe;
    wire up_x1  = a_rise & ~b_eff;
    wire dn_x1  = a_fall & ~b_eff;
    wire up_x2  = up_x1 | (a_fall & b_eff);
    wire dn_x2  = dn_x1 | (a_rise & b_eff);
    wire up_x4  = up_x2 | (b_rise & a) | (b_fall & ~a);
    wire dn_x4  = dn_x2 | (b_rise & ~a) | (b_fall & a);
    wire [1:0] rate = sel54;
    wire up = (rate == qpc_pkg::RATE_X1 & up_x1) | (rate == qpc_pkg::RATE_X2 & up_x2)
            | (rate == qpc_pkg::RATE_X4 & up_x4);
    wire dn = (rate == qpc_pkg::RATE_X1 & dn_x1) | (rate == qpc_pkg::RATE_X2 & dn_x2)
            | (rate == qpc_pkg::RATE_X4 & dn_x4);
    wire phase_ok = (iph == qpc_pkg::IPH_A0B1 & ~a & b_eff) | (iph == qpc_pkg::IPH_A1B0 & a & ~b_eff)
                  | (iph == qpc_pkg::IPH_A1B1 & a & b_eff) | (iph == qpc_pkg::IPH_A0B0 & ~a & ~b_eff);
    wire idx_hit  = is_quad & flt[2] & phase_ok;
    wire reload   = idx_hit & icond == qpc_pkg::ICOND_RELOAD;
    wire cnt_eq_a = cnt_q[15:0] == const_a_q;
    wire eq_hit   = is_quad & icond == qpc_pkg::ICOND_EQ_A & cnt_eq_a;
    // 16-bit arithmetic so the position wraps both ways
    wire [15:0] cnt_inc = cnt_q[15:0] + 16'h0001;
    wire [15:0] cnt_dec = cnt_q[15:0] - 16'h0001;

    // ------------------------------------------------------------
    // pwm clocking, gate and trigger
    // ------------------------------------------------------------
    wire        ext_sel  = (sel76 == qpc_pkg::SEL_LOW | sel76 == qpc_pkg::SEL_HIGH)
                         & clk_src == qpc_pkg::CLK_EXT;
    wire        b_raw_rs = flt[1] & ~flt_p_q[1];
    wire [2:0]  src_clip = (clk_src > qpc_pkg::CLK_FASTEST) ? qpc_pkg::CLK_FASTEST : clk_src;
    wire [2:0]  shamt    = src_clip + {CARRIER_32M, 1'b0};
    wire [24:0] acc_sum  = {1'b0, acc_q} + {1'b0, qpc_pkg::TICK_INC_BASE << shamt};
    wire        tick     = ext_sel ? b_raw_rs : tick_q;
    wire        fast     = ~ext_sel & clk_src == qpc_pkg::CLK_FASTEST;
    wire        gate_ok  = (sel54 == qpc_pkg::SEL_LOW) ? ~a :
                           (sel54 == qpc_pkg::SEL_HIGH) ? a : 1'b1;
    wire        c_rise   = flt[2] & ~flt_p_q[2];
    wire        c_fall   = ~flt[2] & flt_p_q[2];
    wire        ext_trig = (sel98 == qpc_pkg::SEL_LOW & c_fall) | (sel98 == qpc_pkg::SEL_HIGH & c_rise);
    wire        pwm_trig = is_pwm & (wr_trig | ext_trig);
    // one extra cycle on the fastest clock matches the original counter
    wire [16:0] ld_a     = {1'b0, const_a_q} + {16'h0000, fast};
    wire [16:0] ld_b     = {1'b0, const_b_q} + {16'h0000, fast};
    wire        pwm_run  = state_q != qpc_pkg::QPC_IDLE;
    wire        pwm_step = is_pwm & pwm_run & tick & gate_ok;
    wire        pwm_end  = cnt_q <= 17'h00001;
    wire        pwm_tgl  = pwm_step & pwm_end & ~pwm_trig;

    // ------------------------------------------------------------
    // counter and pwm sequencer
    // ------------------------------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        state_d = state_q;
        if (is_pwm) begin
            case (state_q)
                qpc_pkg::QPC_IDLE: begin
                    if (pwm_trig) begin
                        state_d = qpc_pkg::QPC_SPACE;
                        cnt_d   = ld_a;
                    end
                end
                qpc_pkg::QPC_SPACE: begin
                    if (pwm_trig) begin
                        cnt_d = ld_a;
                    end else if (pwm_step && pwm_end) begin
                        state_d = qpc_pkg::QPC_PULSE;
                        cnt_d   = ld_b;
                    end else if (pwm_step) begin
                        cnt_d = cnt_q - 17'h00001;
                    end
                end
                qpc_pkg::QPC_PULSE: begin
                    if (pwm_trig) begin
                        state_d = qpc_pkg::QPC_SPACE;
                        cnt_d   = ld_a;
                    end else if (pwm_step && pwm_end) begin
                        state_d = qpc_pkg::QPC_SPACE;
                        cnt_d   = ld_a;
                    end else if (pwm_step) begin
                        cnt_d = cnt_q - 17'h00001;
                    end
                end
                default: begin
                    state_d = qpc_pkg::QPC_IDLE;
                end
            endcase
        end else begin
            state_d = qpc_pkg::QPC_IDLE;
            if (is_quad && run_q) begin
                if (reload) begin
                    cnt_d = {1'b0, const_b_q};
                end else if (up && !dn) begin
                    cnt_d = {1'b0, cnt_inc};
                end else if (dn && !up) begin
                    cnt_d = {1'b0, cnt_dec};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt and output
    // ------------------------------------------------------------
    // quadrature events are levels: a cleared flag sets again if still true
    wire irq_ev  = (is_quad & (eq_hit | (icond[1] & idx_hit))) | (is_pwm & pwm_tgl);
    wire pend_d  = ien & (irq_ev | (pend_q & ~irq_clr));
    wire out_act = (eq_hit | (is_quad & cfg_q[11] & idx_hit))
                 | (is_pwm & state_d == qpc_pkg::QPC_PULSE);
    wire out_d   = out_act ? pol : ~pol;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] cfg_rd  = is_quad ? (cfg_q & ~(16'h0001 << qpc_pkg::SPARE12_BIT)) : cfg_q;
    wire [15:0] rd_mux  = (ADDR == qpc_pkg::OFF_CFG)      ? cfg_rd :
                          (ADDR == qpc_pkg::OFF_CONST_A)  ? const_a_q :
                          (ADDR == qpc_pkg::OFF_CONST_B)  ? const_b_q :
                          (ADDR == qpc_pkg::OFF_READBACK) ? cnt_q[15:0] :
                          (ADDR == qpc_pkg::OFF_IRQ_STAT) ? {15'h0000, pend_q} : 16'h0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cfg_q     <= qpc_pkg::CFG_RESET;
            const_a_q <= qpc_pkg::CONST_RESET;
            const_b_q <= qpc_pkg::CONST_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= cfg_wr;
            end
            if (wr_ca) begin
                const_a_q <= WDATA;
            end
            if (wr_cb) begin
                const_b_q <= WDATA;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cnt_q   <= 17'h00000;
            state_q <= qpc_pkg::QPC_IDLE;
            flt_p_q <= 3'h0;
            acc_q   <= 24'h000000;
            tick_q  <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            state_q <= state_d;
            flt_p_q <= flt;
            acc_q   <= acc_sum[23:0];
            tick_q  <= acc_sum[24];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            run_q   <= 1'b0;
            pend_q  <= 1'b0;
            out_q   <= 1'b1;
            rdata_q <= 16'h0000;
        end else begin
            run_q   <= is_quad & (run_q | wr_trig);
            pend_q  <= pend_d;
            out_q   <= out_d;
            rdata_q <= RD_STB ? rd_mux : 16'h0000;
        end
    end

    assign RDATA   = rdata_q;
    assign CNT_OUT = out_q;
    assign INT_REQ = pend_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    property p_cfg_reset;
        $past(RESET) |-> cfg_q == 16'h0000;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("control not cleared by reset");

    property p_rate_off;
        (is_quad && rate == 2'h0 && !reload && !wr_cfg) |=> cnt_q == $past(cnt_q);
    endproperty
    a_rate_off: assert property (p_rate_off) else $error("count moved with decoding off");

    property p_x1_up;
        (is_quad && run_q && rate == 2'h1 && a_rise && !b_eff && !reload && !wr_cfg)
            |=> cnt_q[15:0] == $past(cnt_q[15:0]) + 16'h0001;
    endproperty
    a_x1_up: assert property (p_x1_up) else $error("single edge count up missed");

    property p_chb_off;
        (!cfg_q[6] && is_quad && run_q && rate == 2'h3 && !a_rise && !a_fall && !reload && !wr_cfg)
            |=> cnt_q == $past(cnt_q);
    endproperty
    a_chb_off: assert property (p_chb_off) else $error("disabled channel B counted");

    property p_idx_reload;
        (is_quad && run_q && idx_hit && icond == 2'h2 && !wr_cfg && !wr_cb) ##1 1'b1
            |-> cnt_q[15:0] == $past(const_b_q);
    endproperty
    a_idx_reload: assert property (p_idx_reload) else $error("index reload missed");

    property p_spare_read;
        (RD_STB && ADDR == 8'h00 && is_quad) |=> RDATA[12] == 1'b0 && RDATA[14] == 1'b0;
    endproperty
    a_spare_read: assert property (p_spare_read) else $error("spare control bits read nonzero");

    property p_eq_out;
        (is_quad && icond == 2'h1 && cnt_q[15:0] == const_a_q) |=> CNT_OUT == $past(cfg_q[3]);
    endproperty
    a_eq_out: assert property (p_eq_out) else $error("output not active on equal");

    property p_ien_off;
        !cfg_q[15] |=> !INT_REQ;
    endproperty
    a_ien_off: assert property (p_ien_off) else $error("interrupt with enable clear");

    property p_pwm_irq;
        (pwm_tgl && ien) |=> INT_REQ;
    endproperty
    a_pwm_irq: assert property (p_pwm_irq) else $error("pwm edge without interrupt");

    property p_gate_hold;
        (is_pwm && pwm_run && !gate_ok && !pwm_trig && !wr_cfg) |=> cnt_q == $past(cnt_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated pwm still counting");

    c_quad_up:   cover property (is_quad && run_q && up ##1 cnt_q != 17'h00000);
    c_reload:    cover property (reload && run_q);
    c_pwm_pulse: cover property (state_q == qpc_pkg::QPC_SPACE ##1 state_q == qpc_pkg::QPC_PULSE);
    c_irq:       cover property (INT_REQ ##1 irq_clr);
endmodule // qpc_channel

// [pkg/qpc_pkg.sv]
// Functional notes
// - bits 5:4 pick quadrature rate: off, single, double or four-edge decoding
// - bit 6 enables channel B; cleared means B reads as zero
// - bits 9:7 pick the A,B phase in which a high index fires
// - bits 11:10: none, equal constant A, index with reload B, index only
// - bits 12 and 14 ignore writes and read zero in quadrature mode
// - bit 13 rejects A, B, index pulses of 2.5 us or less
// - bit 15 enables interrupt requests; cleared suppresses them
// - code 01: output active while the count equals constant A
// - bit 11 set: output active while the index condition holds
// - mode 010 selects free-running pulse-width modulation once started
// - constant A sets idle time, constant B pulse time, pulse follows polarity
// - counter drops per selected clock edge, toggles and reloads at zero
// - fastest internal clock adds one clock cycle to each interval
// - bits 5:4 make input A a gate-off, low or high allowing counting
// - external clock on B needs bits 7:6 at 01/10 and source 101
// - waveform starts on external trigger on C or software trigger write
// - with bit 15 set every output edge at the end of an interval raises an interrupt
// - mode 001 selects the quadrature position counter
// - count up when A leads B, down when B leads A
// - quadrature interrupt pends until cleared, then rises again if still true
// - reset clears the whole control register, disabling the channel
package qpc_pkg;
    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int              ADDR_W       = 8;
    localparam int              DATA_W       = 16;
    localparam logic [7:0]      OFF_CFG      = 8'h00;
    localparam logic [7:0]      OFF_TRIG     = 8'h04;
    localparam logic [7:0]      OFF_CONST_A  = 8'h08;
    localparam logic [7:0]      OFF_CONST_B  = 8'h0C;
    localparam logic [7:0]      OFF_READBACK = 8'h10;
    localparam logic [7:0]      OFF_IRQ_STAT = 8'h14;
    localparam logic [15:0]     CFG_RESET    = 16'h0000;
    localparam logic [15:0]     CONST_RESET  = 16'h0000;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int              POL_BIT      = 3;
    localparam int              CHB_BIT      = 6;
    localparam int              SPARE12_BIT  = 12;
    localparam int              DEB_BIT      = 13;
    localparam int              SPARE14_BIT  = 14;
    localparam int              IEN_BIT      = 15;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [2:0]      MODE_QUAD    = 3'h1;
    localparam logic [2:0]      MODE_PWM     = 3'h2;
    localparam logic [1:0]      RATE_X1      = 2'h1;
    localparam logic [1:0]      RATE_X2      = 2'h2;
    localparam logic [1:0]      RATE_X4      = 2'h3;
    localparam logic [2:0]      IPH_A0B1     = 3'h1;
    localparam logic [2:0]      IPH_A1B0     = 3'h2;
    localparam logic [2:0]      IPH_A1B1     = 3'h3;
    localparam logic [2:0]      IPH_A0B0     = 3'h4;
    localparam logic [1:0]      ICOND_EQ_A   = 2'h1;
    localparam logic [1:0]      ICOND_RELOAD = 2'h2;
    localparam logic [1:0]      SEL_LOW      = 2'h1;
    localparam logic [1:0]      SEL_HIGH     = 2'h2;
    localparam logic [2:0]      CLK_FASTEST  = 3'h4;
    localparam logic [2:0]      CLK_EXT      = 3'h5;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int              CLK_PERIOD_PS = 8000;
    localparam int              DEB_TIME_PS   = 2500000;
    localparam int              DEB_CYC       = (DEB_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [8:0]      DEB_LAST      = 9'(DEB_CYC - 1);
    localparam longint          CLK_FREQ_KHZ  = 125000;
    localparam longint          BASE_FREQ_KHZ = 500;
    localparam int              ACC_W         = 24;
    localparam logic [23:0]     TICK_INC_BASE = 24'((BASE_FREQ_KHZ * (64'd1 << ACC_W)) / CLK_FREQ_KHZ);

    typedef enum logic [1:0] {
        QPC_IDLE  = 2'b00,
        QPC_SPACE = 2'b01,
        QPC_PULSE = 2'b11
    } qpc_state_t;
endpackage

// [core/qpc_deglitch.sv]
`timescale 1ns/10ps
module qpc_deglitch (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // filter control
    input  wire logic en,
    input  wire logic raw,
    // filtered level
    output logic      clean
);
    // ------------------------------------------------------------
    // pulse rejection
    // ------------------------------------------------------------
    logic       clean_q;
    logic [8:0] run_q;
    wire        differs  = raw != clean_q;
    wire        long_run = run_q == qpc_pkg::DEB_LAST;

    // a change is taken only after it outlasts the reject window
    always_ff @(posedge clk) begin
        if (rst) begin
            clean_q <= 1'b0;
            run_q   <= 9'h000;
        end else if (!en) begin
            clean_q <= raw;
            run_q   <= 9'h000;
        end else if (differs && long_run) begin
            clean_q <= raw;
            run_q   <= 9'h000;
        end else if (differs) begin
            run_q   <= run_q + 9'h001;
        end else begin
            run_q   <= 9'h000;
        end
    end

    assign clean = clean_q;
endmodule // qpc_deglitch

// [test/qpc_encoder.sv]
`timescale 1ns/10ps
module qpc_encoder (
    // clock
    input  wire logic clk,
    // encoder lines
    output logic      a,
    output logic      b
);
    int ph = 0;
    initial begin
        a = 1'b0;
        b = 1'b0;
    end
    // gray order 00,10,11,01: forward means a leads b
    task automatic step(input int dir);
        @(posedge clk);
        ph = (ph + dir) & 3;
        a <= (ph == 1) || (ph == 2);
        b <= (ph >= 2);
        repeat (8) @(posedge clk);
    endtask
    task automatic set_a(input logic v);
        @(posedge clk);
        a <= v;
    endtask
    // one rising edge on b, each level held 4 cycles, too short for the enabled filter
    task automatic tick();
        @(posedge clk);
        b <= 1'b0;
        repeat (4) @(posedge clk);
        b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule // qpc_encoder

// [test/qpc_channel_tb.sv]
`timescale 1ns/10ps
module qpc_channel_tb;
    // --------------------------------
    // signals
    // --------------------------------
    logic        REF_CLK = 1'b0;
    logic        RESET   = 1'b1;
    logic [7:0]  ADDR    = 8'h00;
    logic [15:0] WDATA   = 16'h0000;
    logic        WR_STB  = 1'b0;
    logic        RD_STB  = 1'b0;
    logic        IN_C    = 1'b0;
    logic [15:0] RDATA;
    logic        CNT_OUT;
    logic        INT_REQ;
    logic        enc_a;
    logic        enc_b;
    logic [31:0] seed = 32'h0000_0050;
    logic [15:0] d;
    logic [15:0] bv;
    logic        lvl;
    logic        tog;
    logic        gate;
    int          mismatches = 0;
    int          total_checks = 0;
    int          cnt_m = 0;
    int          ca;
    int          cb;
    int          cnt;
    int          iph[4] = '{2, 3, 1, 4};
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    qpc_channel dut (.REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
        .RD_STB(RD_STB), .RDATA(RDATA), .IN_A(enc_a), .IN_B(enc_b), .IN_C(IN_C),
        .CARRIER_32M(1'b0), .CNT_OUT(CNT_OUT), .INT_REQ(INT_REQ));
    qpc_encoder enc (.clk(REF_CLK), .a(enc_a), .b(enc_b));
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= v;
        WR_STB <= 1'b1;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1 v = RDATA;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    // count step of one encoder move at rate r from phase f
    function automatic int qd(input int r, input int f, input int dir);
        if (r == 3) return dir;
        if (r == 2) return (((dir > 0) ? f % 2 == 0 : f % 2 == 1) ? dir : 0);
        if (r == 1) return (((dir > 0 && f == 0) || (dir < 0 && f == 1)) ? dir : 0);
        return 0;
    endfunction
    task automatic mv(input int r, input int dir);
        cnt_m += qd(r, enc.ph, dir);
        enc.step(dir);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge REF_CLK);
        mismatches++;
        report_and_stop();
    end
    // --------------------------------
    // sequence
    // --------------------------------
    initial begin
        repeat (3) @(posedge REF_CLK);
        RESET <= 1'b0;
        wait_n(1);
        chk_pin("out idle", 1'b1, CNT_OUT);
        rd(qpc_pkg::OFF_CFG, d);
        chk_reg("cfg reset", qpc_pkg::CFG_RESET, d);
        rd(8'h20, d);
        chk_reg("unmapped", 16'h0000, d);
        wr(qpc_pkg::OFF_CFG, 16'h5079);
        rd(qpc_pkg::OFF_CFG, d);
        chk_reg("cfg spare", 16'h0079, d);
        wr(qpc_pkg::OFF_TRIG, rnd());
        for (int r = 3; r >= 0; r--) begin
            wr(qpc_pkg::OFF_CFG, 16'h0049 | 16'(r << 4));
            repeat (8) mv(r, -1);
            repeat (4) mv(r, 1);
            rd(qpc_pkg::OFF_READBACK, d);
            chk_reg("count", 16'(cnt_m), d);
        end
        // short glitch on a must not count
        wr(qpc_pkg::OFF_CFG, 16'h2079);
        enc.set_a(1'b1);
        wait_n(100);
        // an unfiltered rise would already have counted here
        rd(qpc_pkg::OFF_READBACK, d);
        chk_reg("glitch", 16'(cnt_m), d);
        enc.set_a(1'b0);
        wait_n(400);
        rd(qpc_pkg::OFF_READBACK, d);
        chk_reg("debounced", 16'(cnt_m), d);
        $display("quadrature rates done");
        wr(qpc_pkg::OFF_CONST_A, 16'(cnt_m));
        wr(qpc_pkg::OFF_CFG, 16'h8479);
        wait_n(4);
        chk_pin("eq out", 1'b1, CNT_OUT);
        chk_pin("eq irq", 1'b1, INT_REQ);
        rd(qpc_pkg::OFF_IRQ_STAT, d);
        chk_reg("irq stat", 16'h0001, d);
        wr(qpc_pkg::OFF_IRQ_STAT, 16'h0001);
        wait_n(3);
        chk_pin("irq again", 1'b1, INT_REQ);
        mv(3, 1);
        chk_pin("eq out off", 1'b0, CNT_OUT);
        chk_pin("irq held", 1'b1, INT_REQ);
        wr(qpc_pkg::OFF_IRQ_STAT, 16'h0001);
        wait_n(3);
        chk_pin("irq clear", 1'b0, INT_REQ);
        $display("compare interrupt done");
        bv = rnd();
        wr(qpc_pkg::OFF_CONST_B, bv);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) mv(3, 1);
            wr(qpc_pkg::OFF_CFG, 16'h0C79 | 16'(iph[i] << 7));
            IN_C <= 1'b1;
            wait_n(6);
            chk_pin("index out", 1'b1, CNT_OUT);
            chk_pin("irq masked", 1'b0, INT_REQ);
            @(posedge REF_CLK);
            IN_C <= 1'b0;
            wait_n(6);
            chk_pin("index off", 1'b0, CNT_OUT);
        end
        wr(qpc_pkg::OFF_CFG, 16'h0EF9);
        IN_C <= 1'b1;
        wait_n(6);
        chk_pin("index code off", 1'b0, CNT_OUT);
        wr(qpc_pkg::OFF_CFG, 16'h0A79);
        wait_n(6);
        @(posedge REF_CLK);
        IN_C <= 1'b0;
        rd(qpc_pkg::OFF_READBACK, d);
        chk_reg("reload", bv, d);
        $display("index done");
        ca = int'(rnd() % 3) + 2;
        cb = int'(rnd() % 3) + 2;
        wr(qpc_pkg::OFF_CONST_A, 16'(ca));
        wr(qpc_pkg::OFF_CONST_B, 16'(cb));
        wr(qpc_pkg::OFF_CFG, 16'h945A);
        wr(qpc_pkg::OFF_TRIG, rnd());
        lvl = 1'b0;
        cnt = ca;
        // running: no retrigger and no control write from here on
        for (int t = 0; t < 24; t++) begin
            gate = (t >= 10 && t < 13);
            enc.set_a(gate);
            enc.tick();
            wait_n(4);
            tog = 1'b0;
            if (!gate) cnt--;
            if (cnt == 0) begin
                lvl = !lvl;
                cnt = lvl ? cb : ca;
                tog = 1'b1;
            end
            chk_pin("pwm out", lvl, CNT_OUT);
            chk_pin("pwm irq", tog, INT_REQ);
            if (tog) wr(qpc_pkg::OFF_IRQ_STAT, 16'h0001);
        end
        $display("pwm done");
        // stop, then start again from a rising edge on C
        wr(qpc_pkg::OFF_CFG, 16'h0000);
        wr(qpc_pkg::OFF_CFG, 16'h965A);
        IN_C <= 1'b1;
        repeat (ca) enc.tick();
        wait_n(4);
        chk_pin("ext trig", 1'b1, CNT_OUT);
        $display("external trigger done");
        report_and_stop();
    end
endmodule // qpc_channel_tb
